/* File: frps_defs.svh */
// Offsets, fields, reset values and timing for the flash row program sequencer
// Overview of operation
// - Row-erase select set before start gives an erase; otherwise start programs.
// - A table store is a short latch write; pre-increment form advances pointer.
// - Write starts only after 55h then AAh to unlock, then start bit.
// - Valid start begins a self-timed write; processor stalls about 2 ms.
// - A master clear or watchdog reset during a write sets the error flag.
// - Store uses pointer bits 2:0; program uses bits 21:3 as block.
// - Row erase uses pointer bits 21:6; bits 5:0 are ignored.
// - Start bit set only by software, cleared at completion, needs write enable.
// - Completion sets the nonvolatile-memory done flag; software clears it.
`ifndef FRPS_DEFS_SVH
`define FRPS_DEFS_SVH

// Register offsets on the register port
`define FRPS_ADDR_W          4
`define FRPS_OFF_PTR_UPPER   4'h0
`define FRPS_OFF_PTR_HIGH    4'h1
`define FRPS_OFF_PTR_LOW     4'h2
`define FRPS_OFF_LATCH       4'h3
`define FRPS_OFF_INT_CTRL    4'h4
`define FRPS_OFF_UNLOCK      4'h5
`define FRPS_OFF_MEM_CTRL    4'h6
`define FRPS_OFF_PRIO2       4'h7
`define FRPS_OFF_FLAGS2      4'h8
`define FRPS_OFF_ENABLES2    4'h9
`define FRPS_OFF_TABLE_CMD   4'ha

// Memory control bit positions
`define FRPS_MC_PGM_SEL      7
`define FRPS_MC_CFG_SEL      6
`define FRPS_MC_ROW_ERASE    4
`define FRPS_MC_WR_ERR       3
`define FRPS_MC_WR_EN        2
`define FRPS_MC_START        1
`define FRPS_MC_READ         0

// Interrupt bits
`define FRPS_INT_GIE         7
`define FRPS_FLAG_NVM_DONE   4

// Table command fields
`define FRPS_TC_STORE        2

// Reset values and the priority write mask
`define FRPS_RST_PRIO2       8'h96
`define FRPS_PRIO2_MASK      8'h96
`define FRPS_RST_BYTE        8'h00

// Unlock keys
`define FRPS_KEY_FIRST       8'h55
`define FRPS_KEY_SECOND      8'haa

// Pointer geometry
`define FRPS_PTR_W           22
`define FRPS_HOLD_N          8

// Long write timing
`define FRPS_LONG_WRITE_US   2000
`define FRPS_CLK_MHZ         40
`define FRPS_LONG_WRITE_CYC  (`FRPS_LONG_WRITE_US * `FRPS_CLK_MHZ)

`endif

/* File: frps_pkg.sv */
// Types for the flash row program sequencer
package frps_pkg;

	// Unlock sequence tracker
	typedef enum logic [1:0] {
		FRPS_UL_IDLE  = 2'b00,
		FRPS_UL_FIRST = 2'b01,
		FRPS_UL_ARMED = 2'b10
	} frps_unlock_t;

	// Table pointer update modes carried in the table command
	typedef enum logic [1:0] {
		FRPS_TM_KEEP     = 2'b00,
		FRPS_TM_POST_INC = 2'b01,
		FRPS_TM_POST_DEC = 2'b10,
		FRPS_TM_PRE_INC  = 2'b11
	} frps_tmode_t;

	// Long write kind
	typedef enum logic [1:0] {
		FRPS_OP_NONE    = 2'b00,
		FRPS_OP_PROGRAM = 2'b01,
		FRPS_OP_ERASE   = 2'b10
	} frps_op_t;

endpackage

/* File: frps_hold_mem.sv */
// Eight-byte holding memory for one program block
`timescale 1ns/1ps
`include "frps_defs.svh"
module frps_hold_mem #(
	parameter int N = `FRPS_HOLD_N
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Byte write port
	input  wire logic                   wr_en,
	input  wire logic [$clog2(N)-1:0]   wr_idx,
	input  wire logic [7:0]             wr_data,
	// Whole block, registered
	output logic      [N*8-1:0]         blk_q
);
	// Elaboration guard: the byte index must cover exactly N entries
	if (N < 2 || (N & (N - 1)) != 0) begin
		$error("frps_hold_mem: N must be a power of two of at least 2");
	end

	logic [N*8-1:0] blk_d;

	// Next block image with one byte replaced
	always_comb begin
		blk_d = blk_q;
		if (wr_en) begin
			blk_d[wr_idx*8 +: 8] = wr_data;
		end
	end

	// Holding bytes start erased-looking after reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			blk_q <= '1;
		end else begin
			blk_q <= blk_d;
		end
	end
endmodule

/* File: frps_top.sv */
// Flash row program sequencer: registers, unlock, table ops and long write
`timescale 1ns/1ps
`include "frps_defs.svh"
module frps_top
	import frps_pkg::*;
#(
	parameter int LONG_WRITE_CYC = `FRPS_LONG_WRITE_CYC
) (
	// Clock and resets
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         master_clear_reset,
	input  wire logic                         watchdog_reset,
	// Register port
	input  wire logic [`FRPS_ADDR_W-1:0]      reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [7:0]                   reg_rdata_q,
	// Flash array
	output logic                              flash_rd_q,
	output logic                              flash_prog_q,
	output logic                              flash_erase_q,
	output logic      [`FRPS_PTR_W-1:0]       flash_addr_q,
	output logic      [63:0]                  flash_wdata_q,
	input  wire logic [7:0]                   flash_rdata,
	// Processor side
	output logic                              cpu_stall_q,
	output logic                              irq_q
);
	localparam int TW = $clog2(LONG_WRITE_CYC + 1);
	localparam int PW = `FRPS_PTR_W;

	// Elaboration guard: the timer needs at least one cycle to count
	if (LONG_WRITE_CYC < 1) begin
		$error("frps_top: LONG_WRITE_CYC below 1");
	end

	// Pointer step on the low 21 bits only; bit 21 is left alone
	function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p,
			input logic dec);
		logic [PW-2:0] lo;
		lo = dec ? p[PW-2:0] - 21'd1 : p[PW-2:0] + 21'd1;
		return {p[PW-1], lo};
	endfunction

	// Register state
	logic [PW-1:0]     ptr_q, ptr_d;
	logic [7:0]        latch_q, latch_d;
	logic [7:0]        intc_q, intc_d;
	logic [7:0]        mctl_q, mctl_d;
	logic [7:0]        prio_q, prio_d;
	logic              done_q, done_d;
	logic              done_en_q, done_en_d;
	frps_unlock_t      ul_q, ul_d;
	frps_op_t          op_q, op_d;
	logic [TW-1:0]     tmr_q, tmr_d;
	logic              fetch_q, fetch_d;
	logic [7:0]        rdata_d;
	logic              frd_d, fprog_d, ferase_d, stall_d, irq_d;
	logic [PW-1:0]     faddr_d;
	logic [63:0]       fwdata_d;
	logic              hold_wr;
	logic [2:0]        hold_idx;
	logic [63:0]       hold_blk;
	logic              other_rst;
	logic              busy;

	assign other_rst = master_clear_reset | watchdog_reset;
	assign busy      = (op_q != FRPS_OP_NONE);

	// Holding registers for the block being programmed
	frps_hold_mem #(
		.N       (`FRPS_HOLD_N)
	) u_hold (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (hold_wr),
		.wr_idx  (hold_idx),
		.wr_data (latch_q),
		.blk_q   (hold_blk)
	);

	// Next state for registers, unlock, table ops and the long write
	always_comb begin
		logic [PW-1:0] p;
		logic          wr_hit;
		p         = ptr_q;
		wr_hit    = 1'b0;
		ptr_d     = ptr_q;
		latch_d   = latch_q;
		intc_d    = intc_q;
		mctl_d    = mctl_q;
		prio_d    = prio_q;
		done_d    = done_q;
		done_en_d = done_en_q;
		ul_d      = ul_q;
		op_d      = op_q;
		tmr_d     = tmr_q;
		fetch_d   = 1'b0;
		frd_d     = 1'b0;
		fprog_d   = 1'b0;
		ferase_d  = 1'b0;
		faddr_d   = flash_addr_q;
		fwdata_d  = flash_wdata_q;
		hold_wr   = 1'b0;
		hold_idx  = ptr_q[2:0];
		rdata_d   = 8'h00;

		// Fetched byte lands in the latch one cycle after the request
		if (fetch_q) begin
			latch_d = flash_rdata;
		end

		// Self-timed write; the stall keeps the bus quiet meanwhile
		if (busy) begin
			if (tmr_q == TW'(1)) begin
				op_d = FRPS_OP_NONE;
				mctl_d[`FRPS_MC_START] = 1'b0;
				mctl_d[`FRPS_MC_ROW_ERASE] = 1'b0;
				done_d = 1'b1;
			end
			tmr_d = tmr_q - TW'(1);
		end else if (reg_wr) begin
			// Any write other than a key write ends an armed sequence
			if (reg_addr != `FRPS_OFF_UNLOCK) begin
				ul_d = FRPS_UL_IDLE;
			end
			if (reg_addr == `FRPS_OFF_PTR_UPPER) begin
				ptr_d[21:16] = reg_wdata[5:0];
			end else if (reg_addr == `FRPS_OFF_PTR_HIGH) begin
				ptr_d[15:8] = reg_wdata;
			end else if (reg_addr == `FRPS_OFF_PTR_LOW) begin
				ptr_d[7:0] = reg_wdata;
			end else if (reg_addr == `FRPS_OFF_LATCH) begin
				latch_d = reg_wdata;
			end else if (reg_addr == `FRPS_OFF_INT_CTRL) begin
				intc_d = reg_wdata;
			end else if (reg_addr == `FRPS_OFF_UNLOCK) begin
				// Exact 55h then AAh, nothing between
				if (ul_q == FRPS_UL_IDLE &&
						reg_wdata == `FRPS_KEY_FIRST) begin
					ul_d = FRPS_UL_FIRST;
				end else if (ul_q == FRPS_UL_FIRST &&
						reg_wdata == `FRPS_KEY_SECOND) begin
					ul_d = FRPS_UL_ARMED;
				end else begin
					ul_d = FRPS_UL_IDLE;
				end
			end else if (reg_addr == `FRPS_OFF_MEM_CTRL) begin
				mctl_d[`FRPS_MC_PGM_SEL]   = reg_wdata[`FRPS_MC_PGM_SEL];
				mctl_d[`FRPS_MC_CFG_SEL]   = reg_wdata[`FRPS_MC_CFG_SEL];
				mctl_d[`FRPS_MC_ROW_ERASE] =
					reg_wdata[`FRPS_MC_ROW_ERASE];
				mctl_d[`FRPS_MC_WR_EN]     = reg_wdata[`FRPS_MC_WR_EN];
				// Error flag may be cleared, never set, by software
				if (!reg_wdata[`FRPS_MC_WR_ERR]) begin
					mctl_d[`FRPS_MC_WR_ERR] = 1'b0;
				end
				// Start needs arming and write enable already set
				wr_hit = reg_wdata[`FRPS_MC_START] &&
					ul_q == FRPS_UL_ARMED &&
					mctl_q[`FRPS_MC_WR_EN];
				if (wr_hit) begin
					mctl_d[`FRPS_MC_START] = 1'b1;
					tmr_d = TW'(LONG_WRITE_CYC);
					if (mctl_q[`FRPS_MC_ROW_ERASE]) begin
						op_d = FRPS_OP_ERASE;
						ferase_d = 1'b1;
						faddr_d = {ptr_q[21:6], 6'h00};
					end else begin
						op_d = FRPS_OP_PROGRAM;
						fprog_d = 1'b1;
						faddr_d = {ptr_q[21:3], 3'h0};
						fwdata_d = hold_blk;
					end
				end
			end else if (reg_addr == `FRPS_OFF_PRIO2) begin
				prio_d = reg_wdata & `FRPS_PRIO2_MASK;
			end else if (reg_addr == `FRPS_OFF_FLAGS2) begin
				if (reg_wdata[`FRPS_FLAG_NVM_DONE]) begin
					done_d = 1'b0;
				end
			end else if (reg_addr == `FRPS_OFF_ENABLES2) begin
				done_en_d = reg_wdata[`FRPS_FLAG_NVM_DONE];
			end else if (reg_addr == `FRPS_OFF_TABLE_CMD) begin
				// Table store or fetch with pointer update
				if (reg_wdata[1:0] == FRPS_TM_PRE_INC) begin
					p = ptr_step(ptr_q, 1'b0);
				end
				if (reg_wdata[`FRPS_TC_STORE]) begin
					hold_wr  = 1'b1;
					hold_idx = p[2:0];
				end else begin
					frd_d   = 1'b1;
					fetch_d = 1'b1;
					faddr_d = p;
				end
				if (reg_wdata[1:0] == FRPS_TM_POST_INC) begin
					p = ptr_step(ptr_q, 1'b0);
				end else if (reg_wdata[1:0] == FRPS_TM_POST_DEC) begin
					p = ptr_step(ptr_q, 1'b1);
				end
				ptr_d = p;
			end
		end

		// Read data, one cycle after the strobe
		if (reg_rd) begin
			if (reg_addr == `FRPS_OFF_PTR_UPPER) begin
				rdata_d = {2'b00, ptr_q[21:16]};
			end else if (reg_addr == `FRPS_OFF_PTR_HIGH) begin
				rdata_d = ptr_q[15:8];
			end else if (reg_addr == `FRPS_OFF_PTR_LOW) begin
				rdata_d = ptr_q[7:0];
			end else if (reg_addr == `FRPS_OFF_LATCH) begin
				rdata_d = latch_q;
			end else if (reg_addr == `FRPS_OFF_INT_CTRL) begin
				rdata_d = intc_q;
			end else if (reg_addr == `FRPS_OFF_MEM_CTRL) begin
				rdata_d = mctl_q;
			end else if (reg_addr == `FRPS_OFF_PRIO2) begin
				rdata_d = prio_q;
			end else if (reg_addr == `FRPS_OFF_FLAGS2) begin
				rdata_d = {3'b000, done_q, 4'h0};
			end else if (reg_addr == `FRPS_OFF_ENABLES2) begin
				rdata_d = {3'b000, done_en_q, 4'h0};
			end
		end

		// Level interrupt from a registered view of the flags
		irq_d   = done_d & done_en_d & intc_d[`FRPS_INT_GIE];
		stall_d = (op_d != FRPS_OP_NONE);

		// Clear or watchdog reset: cut the write short, keep the program and config selects
		if (other_rst) begin
			if (busy) begin
				mctl_d[`FRPS_MC_WR_ERR] = 1'b1;
			end
			mctl_d[`FRPS_MC_ROW_ERASE] = 1'b0;
			mctl_d[`FRPS_MC_WR_EN]     = 1'b0;
			mctl_d[`FRPS_MC_START]     = 1'b0;
			ptr_d     = '0;
			latch_d   = `FRPS_RST_BYTE;
			intc_d    = `FRPS_RST_BYTE;
			prio_d    = `FRPS_RST_PRIO2;
			done_d    = 1'b0;
			done_en_d = 1'b0;
			ul_d      = FRPS_UL_IDLE;
			op_d      = FRPS_OP_NONE;
			tmr_d     = '0;
			fetch_d   = 1'b0;
			frd_d     = 1'b0;
			fprog_d   = 1'b0;
			ferase_d  = 1'b0;
			stall_d   = 1'b0;
			irq_d     = 1'b0;
		end
		// Unimplemented and read bits stay zero
		mctl_d[5] = 1'b0;
		mctl_d[`FRPS_MC_READ] = 1'b0;
	end

	// Registers; power-on reset clears everything but prio_q (loaded with 96h), including the error flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ptr_q         <= '0;
			latch_q       <= `FRPS_RST_BYTE;
			intc_q        <= `FRPS_RST_BYTE;
			mctl_q        <= `FRPS_RST_BYTE;
			prio_q        <= `FRPS_RST_PRIO2;
			done_q        <= 1'b0;
			done_en_q     <= 1'b0;
			ul_q          <= FRPS_UL_IDLE;
			op_q          <= FRPS_OP_NONE;
			tmr_q         <= '0;
			fetch_q       <= 1'b0;
			reg_rdata_q   <= 8'h00;
			flash_rd_q    <= 1'b0;
			flash_prog_q  <= 1'b0;
			flash_erase_q <= 1'b0;
			flash_addr_q  <= '0;
			flash_wdata_q <= 64'h0;
			cpu_stall_q   <= 1'b0;
			irq_q         <= 1'b0;
		end else begin
			ptr_q         <= ptr_d;
			latch_q       <= latch_d;
			intc_q        <= intc_d;
			mctl_q        <= mctl_d;
			prio_q        <= prio_d;
			done_q        <= done_d;
			done_en_q     <= done_en_d;
			ul_q          <= ul_d;
			op_q          <= op_d;
			tmr_q         <= tmr_d;
			fetch_q       <= fetch_d;
			reg_rdata_q   <= rdata_d;
			flash_rd_q    <= frd_d;
			flash_prog_q  <= fprog_d;
			flash_erase_q <= ferase_d;
			flash_addr_q  <= faddr_d;
			flash_wdata_q <= fwdata_d;
			cpu_stall_q   <= stall_d;
			irq_q         <= irq_d;
		end
	end
endmodule

/* File: frps_flash_model.sv */
// Behavioural flash array behind the sequencer
`timescale 1ns/1ps
module frps_flash_model (
	// Clock
	input  wire logic        clk,
	// Array requests
	input  wire logic        rd,
	input  wire logic        prog,
	input  wire logic        erase,
	input  wire logic [21:0] addr,
	input  wire logic [63:0] wdata,
	// Read data
	output logic      [7:0]  rdata
);
	logic [7:0] mem [256];
	logic [7:0] junk_q = 8'h5a;

	// Program and erase land on the pulse; low address bits are ignored
	always @(posedge clk) begin
		junk_q <= ~junk_q;
		if (prog)
			for (int i = 0; i < 8; i++)
				mem[{addr[7:3], 3'(i)}] <= wdata[8*i +: 8];
		if (erase)
			for (int i = 0; i < 64; i++)
				mem[{addr[7:6], 6'(i)}] <= 8'hff;
	end

	// Data only while read, a toggling pattern otherwise
	assign rdata = rd ? mem[addr[7:0]] : junk_q;
endmodule

/* File: frps_top_properties.sv */
// Port assertions for the flash row program sequencer
`timescale 1ns/1ps
`include "frps_defs.svh"
module frps_chk #(
	parameter int LONG_WRITE_CYC = `FRPS_LONG_WRITE_CYC
) (
	// Clock and resets
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        master_clear_reset,
	input wire logic        watchdog_reset,
	// Register port
	input wire logic [3:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata_q,
	// Flash and core side
	input wire logic        flash_prog_q,
	input wire logic        flash_erase_q,
	input wire logic [21:0] flash_addr_q,
	input wire logic        cpu_stall_q
);
	logic [31:0] cnt_q, cnt_d;
	logic        k55_q, k55_d, arm_q, arm_d;

	// Stall length, and a loose copy of the key state: only allows more
	always_comb begin
		cnt_d = cpu_stall_q ? cnt_q + 32'h1 : 32'h0;
		k55_d = reg_wr ? (reg_addr == 4'h5 && reg_wdata == 8'h55) : k55_q;
		arm_d = reg_wr ? (reg_addr == 4'h5 && reg_wdata == 8'haa && k55_q)
			: arm_q;
	end
	always_ff @(posedge clk) begin
		cnt_q <= sys_rst ? 32'h0 : cnt_d;
		k55_q <= sys_rst ? 1'b0 : k55_d;
		arm_q <= sys_rst ? 1'b0 : arm_d;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_prog_align;
		flash_prog_q |-> flash_addr_q[2:0] == 3'h0;
	endproperty
	a_prog_align: assert property (p_prog_align)
		else $error("program address unaligned");
	property p_erase_align;
		flash_erase_q |-> flash_addr_q[5:0] == 6'h0;
	endproperty
	a_erase_align: assert property (p_erase_align)
		else $error("erase address unaligned");
	property p_start_write;
		flash_prog_q || flash_erase_q |-> $past(reg_wr) &&
			$past(reg_addr) == 4'h6 && $past(reg_wdata[1]);
	endproperty
	a_start_write: assert property (p_start_write)
		else $error("operation without start write");
	property p_key_seq;
		flash_prog_q || flash_erase_q |-> $past(arm_q);
	endproperty
	a_key_seq: assert property (p_key_seq)
		else $error("operation without unlock keys");
	property p_stall_follows;
		flash_prog_q || flash_erase_q |->
			cpu_stall_q ##1 (cpu_stall_q && !flash_prog_q && !flash_erase_q);
	endproperty
	a_stall_follows: assert property (p_stall_follows)
		else $error("stall missing after start");
	property p_stall_len;
		$fell(cpu_stall_q) && !$past(master_clear_reset) &&
			!$past(watchdog_reset) && !$past(master_clear_reset, 2) &&
			!$past(watchdog_reset, 2) |-> cnt_q == 32'(LONG_WRITE_CYC);
	endproperty
	a_stall_len: assert property (p_stall_len)
		else $error("long write length wrong");
	property p_reset_cut;
		(master_clear_reset || watchdog_reset) && cpu_stall_q
			|-> ##[1:2] !cpu_stall_q;
	endproperty
	a_reset_cut: assert property (p_reset_cut)
		else $error("reset did not end long write");
	property p_no_restart;
		$past(cpu_stall_q) && cpu_stall_q |-> !flash_prog_q && !flash_erase_q;
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("new operation during stall");
	property p_rdata_idle;
		!reg_rd |=> reg_rdata_q == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read slot");
endmodule

bind frps_top frps_chk #(.LONG_WRITE_CYC(LONG_WRITE_CYC)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .master_clear_reset(master_clear_reset),
	.watchdog_reset(watchdog_reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q), .flash_prog_q(flash_prog_q),
	.flash_erase_q(flash_erase_q), .flash_addr_q(flash_addr_q),
	.cpu_stall_q(cpu_stall_q)
);

/* File: frps_testbench.sv */
// Self-checking bench for the flash row program sequencer
`timescale 1ns/1ps
`include "frps_defs.svh"
module testbench;
	localparam int LWC = 20;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        master_clear_reset, watchdog_reset, reg_wr, reg_rd;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata_q, flash_rdata;
	logic        flash_rd_q, flash_prog_q, flash_erase_q, cpu_stall_q, irq_q;
	logic [21:0] flash_addr_q, base, ad;
	logic [63:0] flash_wdata_q, wd;
	logic [1:0]  seen;
	logic [31:0] seed = 32'h896b;
	logic [7:0]  row [64];
	int          error_cnt = 0;
	int          num_checks = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	frps_top #(.LONG_WRITE_CYC(LWC)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .master_clear_reset(master_clear_reset),
		.watchdog_reset(watchdog_reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .flash_rd_q(flash_rd_q),
		.flash_prog_q(flash_prog_q), .flash_erase_q(flash_erase_q),
		.flash_addr_q(flash_addr_q), .flash_wdata_q(flash_wdata_q),
		.flash_rdata(flash_rdata), .cpu_stall_q(cpu_stall_q), .irq_q(irq_q)
	);
	frps_flash_model u_flash (
		.clk(clk), .rd(flash_rd_q), .prog(flash_prog_q),
		.erase(flash_erase_q), .addr(flash_addr_q), .wdata(flash_wdata_q),
		.rdata(flash_rdata)
	);

	// Expectation helpers and the random source
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [7:0] rst_val(input logic [3:0] a);
		return (a == `FRPS_OFF_PRIO2) ? `FRPS_RST_PRIO2 : 8'h00;
	endfunction
	function automatic logic [63:0] blk(input int g);
		logic [63:0] b;
		for (int i = 0; i < 8; i++)
			b[8*i +: 8] = row[8*g + i];
		return b;
	endfunction

	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// One-cycle strobes; the next access waits for a fresh edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(64'(reg_rdata_q), 64'(e));
	endtask
	task automatic setp(input logic [21:0] p);
		wr(4'h0, {2'b00, p[21:16]});
		wr(4'h1, p[15:8]);
		wr(4'h2, p[7:0]);
	endtask
	task automatic look(input logic [1:0] e);
		seen = 2'b00;
		repeat (3) begin
			@(negedge clk);
			if (flash_prog_q | flash_erase_q) begin
				ad = flash_addr_q;
				wd = flash_wdata_q;
			end
			seen = seen | {flash_erase_q, flash_prog_q};
		end
		chk(64'(seen), 64'(e));
	endtask
	task automatic go(input logic [7:0] ctl, input logic [1:0] e);
		wr(4'h6, ctl & 8'hfd);
		wr(4'h5, 8'h55);
		wr(4'h5, 8'haa);
		wr(4'h6, ctl);
		look(e);
	endtask
	task automatic drain();
		for (int n = 0; n < 100 && cpu_stall_q !== 1'b0; n++)
			@(negedge clk);
		chk(64'(cpu_stall_q), 64'h0);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(negedge clk);
		chk(64'(irq_q), 64'(e));
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		master_clear_reset = 1'b0;
		watchdog_reset = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 12; a++)
			if (a != 10)
				rc(4'(a), rst_val(4'(a)));
		wr(4'h7, 8'hff);
		rc(4'h7, `FRPS_PRIO2_MASK);
		wr(4'h4, 8'h80);
		wr(4'h9, 8'h10);
		// Row erase with junk in the ignored pointer bits
		seed = xs(seed);
		base = {seed[21:7], 7'h40};
		setp({base[21:6], seed[29:24]});
		go(8'h96, 2'b10);
		chk(64'(ad), 64'(base));
		drain();
		rc(4'h6, 8'h84);
		rc(4'h8, 8'h10);
		irq_is(1'b1);
		wr(4'h9, 8'h00);
		irq_is(1'b0);
		wr(4'h9, 8'h10);
		irq_is(1'b1);
		wr(4'h8, 8'h10);
		irq_is(1'b0);
		// Eight groups of random bytes; a write in the stall must be lost
		setp(base - 22'h1);
		for (int g = 0; g < 8; g++) begin
			for (int i = 0; i < 8; i++) begin
				seed = xs(seed);
				row[8*g + i] = seed[7:0];
				wr(4'h3, seed[7:0]);
				wr(4'ha, 8'h07);
			end
			go(8'h86, 2'b01);
			wr(4'h2, 8'h00);
			drain();
			chk(64'(ad), 64'(base + 22'(8*g)));
			chk(wd, blk(g));
		end
		wr(4'h6, 8'h80);
		setp(base);
		for (int k = 0; k < 64; k++) begin
			wr(4'ha, 8'h01);
			rc(4'h3, row[k]);
		end
		// Post-decrement and keep fetches; the upper byte must not move
		wr(4'ha, 8'h02);
		rc(4'h2, 8'(base + 22'd63));
		wr(4'ha, 8'h00);
		rc(4'h3, row[63]);
		rc(4'h2, 8'(base + 22'd63));
		rc(4'h0, {2'b00, base[21:16]});
		// Broken key orders and a start without write enable
		for (int k = 0; k < 3; k++) begin
			wr(4'h6, k == 2 ? 8'h80 : 8'h84);
			wr(4'h5, 8'h55);
			if (k == 0)
				wr(4'h5, 8'h12);
			wr(4'h5, 8'haa);
			if (k == 1)
				wr(4'h2, 8'h00);
			wr(4'h6, k == 2 ? 8'h82 : 8'h86);
			look(2'b00);
			rc(4'h6, k == 2 ? 8'h80 : 8'h84);
		end
		// Either reset in mid-write leaves the error flag
		for (int r = 0; r < 2; r++) begin
			go(8'h86, 2'b01);
			@(posedge clk);
			if (r == 0)
				master_clear_reset <= 1'b1;
			else
				watchdog_reset <= 1'b1;
			@(posedge clk);
			master_clear_reset <= 1'b0;
			watchdog_reset <= 1'b0;
			repeat (2) @(negedge clk);
			chk(64'(cpu_stall_q), 64'h0);
			rc(4'h6, 8'h88);
			wr(4'h6, 8'h80);
			rc(4'h6, 8'h80);
		end
		results();
	end

	// Hang guard, about twenty times the expected run
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		results();
	end
endmodule
